/* File: include/src_ctrl_pkg.sv */
// Constants for the converter lock status and mute control block.
// Assumes a 16-bit register port with byte addresses as printed.
package src_ctrl_pkg;
	localparam int ADDR_W = 16;
	localparam int DATA_W = 16;
	localparam int NUM_PAIRS = 8;
	localparam int GRP_PAIRS = 4;
	localparam int NUM_GRPS = 2;
	localparam int GAIN_W = 8;

	// Register byte addresses
	localparam logic [15:0] GRP0_LOCK_MUTE_ADDR = 16'he101;
	localparam logic [15:0] GRP0_RAMP_DIS_ADDR = 16'he103;
	localparam logic [15:0] GRP1_LOCK_MUTE_ADDR = 16'he141;
	localparam logic [15:0] GRP1_RAMP_DIS_ADDR = 16'he143;
	localparam logic [15:0] IRQ_STATUS_ADDR = 16'he180;
	localparam logic [15:0] IRQ_MASK_ADDR = 16'he182;

	// Field positions
	localparam int MUTE_LSB = 0;
	localparam int LOCK_LSB = 8;
	localparam int RAMP_DIS_BIT = 0;
	localparam int IRQ_SET_LSB = 0;
	localparam int IRQ_CLR_LSB = 8;

	// Reset values
	localparam logic [15:0] REG_RST = 16'h0000;

	// Ramp timing: one gain step per RAMP_STEP_NS
	localparam int CLK_FREQ_MHZ = 125;
	localparam int RAMP_STEP_NS = 1000;
	localparam int RAMP_STEP_CYC = (RAMP_STEP_NS * CLK_FREQ_MHZ + 999) / 1000;
	localparam int DIV_W = 16;
endpackage

/* File: hw/mute_ramp.sv */
// Gain ramp for one stereo converter pair.
// Assumes step_en_i is a one-cycle pulse from the parent divider.
`timescale 1ns/10ps
module mute_ramp #(
	parameter int GAIN_W = src_ctrl_pkg::GAIN_W
) (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic rstn_i,
	// Control
	input wire logic step_en_i,
	input wire logic mute_i,
	input wire logic abrupt_i,
	// Result
	output logic [GAIN_W-1:0] gain_o,
	output logic muted_o
);
	import src_ctrl_pkg::*;

	typedef struct packed {
		logic [GAIN_W-1:0] gain;
		logic muted;
	} ramp_t;

	localparam logic [GAIN_W-1:0] GAIN_MAX = '1;
	localparam logic [GAIN_W-1:0] GAIN_ONE = GAIN_W'(1);

	ramp_t s_reg;
	ramp_t s_next;

	always_comb begin
		s_next = s_reg;
		if (abrupt_i) begin
			// Straight step, no ramp
			s_next.gain = mute_i ? '0 : GAIN_MAX;
		end else if (step_en_i) begin
			// One step per tick, so no click
			if (mute_i && s_reg.gain != '0) begin
				s_next.gain = s_reg.gain - GAIN_ONE;
			end else if (!mute_i && s_reg.gain != GAIN_MAX) begin
				s_next.gain = s_reg.gain + GAIN_ONE;
			end
		end
		s_next.muted = (s_next.gain == '0);
	end

	// Reset leaves the pair at full gain, since mute bits reset to 0
	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			s_reg.gain <= GAIN_MAX;
			s_reg.muted <= 1'b0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign gain_o = s_reg.gain;
	assign muted_o = s_reg.muted;
endmodule

/* File: hw/src_lock_status_mute_ctrl.sv */
// Lock status, mute and ramp control for eight stereo converter pairs.
// Assumes a single-cycle strobe register port and converter status levels
// synchronous to core_clk_i.
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/10ps

// How it works
// - Mute bits [3:0] per pair, active high
// - Ramped mute changes gain gradually, click free
// - Lock bits 8..11, writes ignored
// - All bits read zero after reset
// - Clock enable sets lock bit, mutes pair
// - Lock to output clock clears lock bit
// - Cleared lock bit stays zero until reset
// - Rate change or clock loss never resets
// - Group 0 bit 0 selects abrupt mute
// - Abrupt mode ignores software mute bits
// - Pairs 4..7 use register 0xE141
// - Pairs 4..7 own ramp disable register
module src_lock_status_mute_ctrl #(
	parameter int GAIN_W = src_ctrl_pkg::GAIN_W
) (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic rstn_i,
	// Register port
	input wire logic [src_ctrl_pkg::ADDR_W-1:0] addr_i,
	input wire logic [src_ctrl_pkg::DATA_W-1:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [src_ctrl_pkg::DATA_W-1:0] rdata_o,
	// Converter status
	input wire logic [src_ctrl_pkg::NUM_PAIRS-1:0] mclk_en_i,
	input wire logic [src_ctrl_pkg::NUM_PAIRS-1:0] out_locked_i,
	// Mute results
	output logic [src_ctrl_pkg::NUM_PAIRS*GAIN_W-1:0] gain_o,
	output logic [src_ctrl_pkg::NUM_PAIRS-1:0] muted_o,
	// Interrupt
	output logic irq_o
);
	import src_ctrl_pkg::*;

	typedef struct packed {
		logic [NUM_PAIRS-1:0] mute;
		logic [NUM_GRPS-1:0] ramp_dis;
		logic [NUM_PAIRS-1:0] lock;
		logic [NUM_PAIRS-1:0] done;
		logic [DATA_W-1:0] irq_st;
		logic [DATA_W-1:0] irq_mask;
		logic irq;
		logic [DATA_W-1:0] rdata;
		logic [DIV_W-1:0] div;
		logic tick;
	} ctrl_t;

	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(RAMP_STEP_CYC - 1);
	localparam logic [DIV_W-1:0] DIV_ONE = DIV_W'(1);

	ctrl_t s_reg;
	ctrl_t s_next;
	logic [NUM_PAIRS-1:0] set_ev;
	logic [NUM_PAIRS-1:0] clr_ev;
	logic [NUM_PAIRS-1:0] mute_req;
	logic [NUM_PAIRS-1:0] abrupt;
	logic [DATA_W-1:0] w1c;
	logic [DATA_W-1:0] grp0_word;
	logic [DATA_W-1:0] grp1_word;

	// Lock events; done keeps a pair from arming again until reset
	always_comb begin
		set_ev = mclk_en_i & ~s_reg.lock & ~s_reg.done;
		clr_ev = s_reg.lock & out_locked_i;
	end

	// Per-pair mute request
	always_comb begin
		for (int n = 0; n < NUM_PAIRS; n++) begin
			abrupt[n] = s_reg.ramp_dis[n / GRP_PAIRS];
			// Abrupt mode leaves only the lock-driven mute
			mute_req[n] = s_reg.lock[n] |
				(~abrupt[n] & s_reg.mute[n]);
		end
	end

	// Readback words, reserved bits zero
	always_comb begin
		grp0_word = '0;
		grp1_word = '0;
		grp0_word[MUTE_LSB +: GRP_PAIRS] = s_reg.mute[0 +: GRP_PAIRS];
		grp0_word[LOCK_LSB +: GRP_PAIRS] =
			s_reg.lock[0 +: GRP_PAIRS];
		grp1_word[MUTE_LSB +: GRP_PAIRS] =
			s_reg.mute[GRP_PAIRS +: GRP_PAIRS];
		grp1_word[LOCK_LSB +: GRP_PAIRS] =
			s_reg.lock[GRP_PAIRS +: GRP_PAIRS];
		w1c = (wr_i && addr_i == IRQ_STATUS_ADDR) ? wdata_i : '0;
	end

	always_comb begin
		s_next = s_reg;
		// Ramp step divider
		s_next.tick = 1'b0;
		if (s_reg.div == DIV_LAST) begin
			s_next.div = '0;
			s_next.tick = 1'b1;
		end else begin
			s_next.div = s_reg.div + DIV_ONE;
		end
		// Lock indicators; no path sets a pair once done
		s_next.lock = (s_reg.lock | set_ev) & ~clr_ev;
		s_next.done = s_reg.done | clr_ev;
		// Software writes; lock bits are not writable
		if (wr_i) begin
			unique case (addr_i)
				GRP0_LOCK_MUTE_ADDR:
					s_next.mute[0 +: GRP_PAIRS] =
						wdata_i[MUTE_LSB +: GRP_PAIRS];
				GRP1_LOCK_MUTE_ADDR:
					s_next.mute[GRP_PAIRS +: GRP_PAIRS] =
						wdata_i[MUTE_LSB +: GRP_PAIRS];
				GRP0_RAMP_DIS_ADDR:
					s_next.ramp_dis[0] = wdata_i[RAMP_DIS_BIT];
				GRP1_RAMP_DIS_ADDR:
					s_next.ramp_dis[1] = wdata_i[RAMP_DIS_BIT];
				IRQ_MASK_ADDR:
					s_next.irq_mask = wdata_i;
				default: ; // Other addresses ignored
			endcase
		end
		// Sticky events; a new event beats a same-cycle clear
		s_next.irq_st = s_reg.irq_st & ~w1c;
		s_next.irq_st[IRQ_SET_LSB +: NUM_PAIRS] =
			s_next.irq_st[IRQ_SET_LSB +: NUM_PAIRS] | set_ev;
		s_next.irq_st[IRQ_CLR_LSB +: NUM_PAIRS] =
			s_next.irq_st[IRQ_CLR_LSB +: NUM_PAIRS] | clr_ev;
		s_next.irq = |(s_next.irq_st & s_next.irq_mask);
		// Read data stands one cycle only
		s_next.rdata = '0;
		if (rd_i) begin
			unique case (addr_i)
				GRP0_LOCK_MUTE_ADDR: s_next.rdata = grp0_word;
				GRP1_LOCK_MUTE_ADDR: s_next.rdata = grp1_word;
				GRP0_RAMP_DIS_ADDR:
					s_next.rdata[RAMP_DIS_BIT] = s_reg.ramp_dis[0];
				GRP1_RAMP_DIS_ADDR:
					s_next.rdata[RAMP_DIS_BIT] = s_reg.ramp_dis[1];
				IRQ_STATUS_ADDR: s_next.rdata = s_reg.irq_st;
				IRQ_MASK_ADDR: s_next.rdata = s_reg.irq_mask;
				default: s_next.rdata = '0;
			endcase
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			s_reg.mute <= '0;
			s_reg.ramp_dis <= '0;
			s_reg.lock <= '0;
			s_reg.done <= '0;
			s_reg.irq_st <= REG_RST;
			s_reg.irq_mask <= REG_RST;
			s_reg.irq <= 1'b0;
			s_reg.rdata <= REG_RST;
			s_reg.div <= '0;
			s_reg.tick <= 1'b0;
		end else begin
			s_reg <= s_next;
		end
	end

	// One ramp per pair, sharing the step tick
	genvar g;
	generate
		for (g = 0; g < NUM_PAIRS; g++) begin : g_pair
			mute_ramp #(
				.GAIN_W(GAIN_W)
			) u_ramp (
				.core_clk_i(core_clk_i),
				.rstn_i(rstn_i),
				.step_en_i(s_reg.tick),
				.mute_i(mute_req[g]),
				.abrupt_i(abrupt[g]),
				.gain_o(gain_o[g*GAIN_W +: GAIN_W]),
				.muted_o(muted_o[g])
			);
		end
	endgenerate

	assign rdata_o = s_reg.rdata;
	assign irq_o = s_reg.irq;
endmodule

/* File: verif/src_ctrl_checker.sv */
// Port checker for the converter lock, mute and ramp register block.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/10ps
module src_ctrl_checker
	import src_ctrl_pkg::*;
#(
	parameter int GAIN_W = src_ctrl_pkg::GAIN_W
) (
	// Clock, reset, register port
	input wire logic core_clk_i,
	input wire logic rstn_i,
	input wire logic [ADDR_W-1:0] addr_i,
	input wire logic [DATA_W-1:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [DATA_W-1:0] rdata_o,
	// Results
	input wire logic [NUM_PAIRS*GAIN_W-1:0] gain_o,
	input wire logic [NUM_PAIRS-1:0] muted_o,
	input wire logic irq_o
);
	logic [GAIN_W-1:0] g0;
	assign g0 = gain_o[GAIN_W-1:0];
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rstn_i);
	sequence rd_lm;
		rd_i && (addr_i == GRP0_LOCK_MUTE_ADDR || addr_i == GRP1_LOCK_MUTE_ADDR);
	endsequence
	sequence rd_ramp;
		rd_i && (addr_i == GRP0_RAMP_DIS_ADDR || addr_i == GRP1_RAMP_DIS_ADDR);
	endsequence
	a_reset_values: assert property (
		$rose(rstn_i) |-> gain_o == '1 && !irq_o) else $error("bad reset outputs");
	a_rdata_idle: assert property (
		!$past(rd_i) |-> rdata_o == '0) else $error("rdata not idle zero");
	a_lm_resv: assert property (
		rd_lm |=> rdata_o[15:12] == 4'h0 && rdata_o[7:4] == 4'h0)
		else $error("reserved lock/mute bits set");
	a_ramp_resv: assert property (
		rd_ramp |=> rdata_o[15:1] == 15'h0000) else $error("ramp reg bits set");
	a_unmapped_zero: assert property (
		rd_i && addr_i == 16'he102 |=> rdata_o == '0) else $error("unmapped read");
	a_gain_step: assert property (
		$changed(g0) |-> g0 == 8'h00 || g0 == 8'hff || g0 - $past(g0) == 8'h01
		|| $past(g0) - g0 == 8'h01) else $error("gain jumped mid ramp");
	a_muted_zero: assert property (
		muted_o[0] == (g0 == 8'h00) && muted_o[4] == (gain_o[39:32] == 8'h00))
		else $error("muted flag disagrees with gain");
	a_mask_off: assert property (
		wr_i && addr_i == IRQ_MASK_ADDR && wdata_i == '0 |=> !irq_o)
		else $error("irq with mask cleared");
endmodule

bind src_lock_status_mute_ctrl src_ctrl_checker #(.GAIN_W(GAIN_W)) u_chk (
	.core_clk_i, .rstn_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
	.gain_o, .muted_o, .irq_o);

/* File: verif/tb_src_lock_status_mute_ctrl.sv */
// Self-checking bench: register access, lock events, mute and irq.
// Assumes read data the cycle after the strobe; ramp tick 125 cycles.
`timescale 1ns/10ps
module tb_src_lock_status_mute_ctrl;
	import src_ctrl_pkg::*;
	logic core_clk_i = 0, rstn_i = 0, wr_i = 0, rd_i = 0, irq_o;
	logic [15:0] addr_i = 0, wdata_i = 0, rdata_o;
	logic [7:0] mclk_en_i = 0, out_locked_i = 0, muted_o;
	logic [63:0] gain_o;
	logic [15:0] ra [6] = '{GRP0_LOCK_MUTE_ADDR, GRP0_RAMP_DIS_ADDR,
		GRP1_LOCK_MUTE_ADDR, GRP1_RAMP_DIS_ADDR, IRQ_STATUS_ADDR, IRQ_MASK_ADDR};
	int miscompares = 0, total_checks = 0, cyc = 0;
	always #4 core_clk_i = ~core_clk_i;
	src_lock_status_mute_ctrl dut (.core_clk_i, .rstn_i, .addr_i, .wdata_i,
		.wr_i, .rd_i, .rdata_o, .mclk_en_i, .out_locked_i, .gain_o, .muted_o,
		.irq_o);
	task chk(input string n, input logic [15:0] s, input logic [15:0] e);
		total_checks++;
		if (s !== e) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask
	task wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge core_clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge core_clk_i);
		wr_i <= 1'b0;
	endtask
	task rd(input logic [15:0] a, input logic [15:0] e);
		@(posedge core_clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge core_clk_i);
		rd_i <= 1'b0;
		#1 chk("rdata", rdata_o, e);
	endtask
	task tk(input int n);
		repeat (n) @(posedge core_clk_i);
	endtask
	task tally_and_finish;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Ceiling well above the full ramp plus register traffic
	always @(posedge core_clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 50000) begin
			miscompares++;
			tally_and_finish;
		end
	end
	initial begin
		tk(6);
		rstn_i <= 1'b1;
		foreach (ra[i]) rd(ra[i], REG_RST);
		wr(16'he102, 16'hffff);
		rd(16'he102, 16'h0000);
		// Ramp disable first, so the mute writes cannot start a ramp
		wr(GRP0_RAMP_DIS_ADDR, 16'hffff);
		rd(GRP0_RAMP_DIS_ADDR, 16'h0001);
		wr(GRP1_RAMP_DIS_ADDR, 16'hffff);
		rd(GRP1_RAMP_DIS_ADDR, 16'h0001);
		wr(GRP0_LOCK_MUTE_ADDR, 16'hffff);
		rd(GRP0_LOCK_MUTE_ADDR, 16'h000f);
		wr(GRP1_LOCK_MUTE_ADDR, 16'hfff5);
		rd(GRP1_LOCK_MUTE_ADDR, 16'h0005);
		tk(4);
		#1 chk("muted", {8'h00, muted_o}, 16'h0000);
		$display("test registers done");
		wr(IRQ_MASK_ADDR, 16'hffff);
		@(posedge core_clk_i);
		mclk_en_i <= 8'h11;
		tk(4);
		#1 chk("muted", {8'h00, muted_o}, 16'h0011);
		chk("irq", {15'h0000, irq_o}, 16'h0001);
		rd(GRP0_LOCK_MUTE_ADDR, 16'h010f);
		rd(GRP1_LOCK_MUTE_ADDR, 16'h0105);
		@(posedge core_clk_i);
		out_locked_i <= 8'h11;
		tk(4);
		#1 chk("muted", {8'h00, muted_o}, 16'h0000);
		rd(GRP0_LOCK_MUTE_ADDR, 16'h000f);
		rd(IRQ_STATUS_ADDR, 16'h1111);
		@(posedge core_clk_i);
		mclk_en_i <= 8'h00;
		out_locked_i <= 8'h00;
		tk(3);
		mclk_en_i <= 8'h11;
		tk(4);
		rd(GRP0_LOCK_MUTE_ADDR, 16'h000f);
		rd(GRP1_LOCK_MUTE_ADDR, 16'h0005);
		wr(IRQ_MASK_ADDR, 16'h0000);
		#1 chk("irq", {15'h0000, irq_o}, 16'h0000);
		wr(IRQ_MASK_ADDR, 16'hffff);
		#1 chk("irq", {15'h0000, irq_o}, 16'h0001);
		wr(IRQ_STATUS_ADDR, 16'hffff);
		#1 chk("irq", {15'h0000, irq_o}, 16'h0000);
		rd(IRQ_STATUS_ADDR, 16'h0000);
		$display("test lock done");
		wr(GRP1_RAMP_DIS_ADDR, 16'h0000);
		tk(200);
		#1 chk("ramp", {15'h0000, gain_o[55:48] != 8'hff &&
			gain_o[55:48] != 8'h00}, 16'h0001);
		tk(255 * 125);
		#1 chk("muted", {8'h00, muted_o}, 16'h0050);
		$display("test ramp done");
		@(posedge core_clk_i);
		rstn_i <= 1'b0;
		tk(2);
		rstn_i <= 1'b1;
		tk(3);
		rd(GRP0_LOCK_MUTE_ADDR, 16'h0100);
		rd(GRP1_RAMP_DIS_ADDR, 16'h0000);
		$display("test reset done");
		tally_and_finish;
	end
endmodule
